// ---- logic/csf_defines.svh ----
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// register indices (byte address is four times the index)
`define CSF_STATUS_IDX_BANK0 8'h03
`define CSF_STATUS_IDX_BANK1 8'h83
`define CSF_ADDR_VIEW_IDX 8'h10

// status file address as seen by the instruction stream
`define CSF_STATUS_FILE_ADDR 7'h03

// status field positions
`define CSF_BIT_INDIRECT_BANK 7
`define CSF_BIT_BANK_HIGH 6
`define CSF_BIT_BANK_LOW 5
`define CSF_BIT_WDOG_EXPIRED 4
`define CSF_BIT_SLEEP_ENTERED 3
`define CSF_BIT_ZERO 2
`define CSF_BIT_NIBBLE_CARRY 1
`define CSF_BIT_CARRY 0

// reset value and writable bits of the status byte
`define CSF_STATUS_RESET 8'h18
`define CSF_STATUS_WR_MASK 8'hE7

// bytes in one data-memory bank
`define CSF_BANK_BYTES 128

`endif

// ---- logic/csf_pkg.sv ----
`default_nettype none
package csf_pkg;
	typedef enum logic [1:0] {
		CSF_ALU_NONE = 2'h0,
		CSF_ALU_ADD = 2'h1,
		CSF_ALU_SUB = 2'h2,
		CSF_ALU_LOGIC = 2'h3
	} csf_alu_op_t;

	typedef enum logic [2:0] {
		CSF_ST_IDLE = 3'b001,
		CSF_ST_WR = 3'b010,
		CSF_ST_RD = 3'b100
	} csf_bus_state_t;
endpackage : csf_pkg
`default_nettype wire

// ---- logic/csf_alu_flags.sv ----
`default_nettype none
module csf_alu_flags (
	// operation and operands
	input wire csf_pkg::csf_alu_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_logic_res,
	// flag values and update enables
	output logic zero_val,
	output logic nibble_carry_val,
	output logic carry_val,
	output logic zero_en,
	output logic arith_en
);
	import csf_pkg::*;

	wire is_sub = (alu_op == CSF_ALU_SUB);
	wire is_arith = (alu_op == CSF_ALU_ADD) || is_sub;
	// subtraction adds the two's complement, so carry reads as not-borrow
	wire [7:0] opnd_b = is_sub ? ~alu_b : alu_b;
	wire [8:0] cin = {8'h00, is_sub};
	wire [8:0] full_sum = {1'b0, alu_a} + {1'b0, opnd_b} + cin;
	wire [4:0] low_sum = {1'b0, alu_a[3:0]} + {1'b0, opnd_b[3:0]} + cin[4:0];
	wire [7:0] result = is_arith ? full_sum[7:0] : alu_logic_res;

	assign zero_val = (result == 8'h00);
	assign nibble_carry_val = low_sum[4];
	assign carry_val = full_sum[8];
	assign zero_en = (alu_op != CSF_ALU_NONE);
	assign arith_en = is_arith;
endmodule : csf_alu_flags
`default_nettype wire

// ---- logic/csf_ahb_slave.sv ----
`default_nettype none
module csf_ahb_slave #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave side
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// register side
	output logic reg_wr,
	output logic [7:0] reg_idx,
	output logic [7:0] reg_wdata,
	input wire logic [31:0] reg_rdata
);
	import csf_pkg::*;

	// haddr[9:2] carries the register index
	if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
		$error("csf_ahb_slave: ADDR_W must be 10 to 32");
	end

	csf_bus_state_t state_ff, nxt_state;
	logic [7:0] idx_ff;
	logic [31:0] hrdata_ff;
	logic ready_ff;

	// only whole-word transfers are served; others complete with no effect
	wire take = hsel && htrans[1] && hready;
	wire word = (hsize == 3'h2);
	wire [7:0] addr_idx = haddr[9:2];

	always_comb begin
		nxt_state = CSF_ST_IDLE;
		if (take && word) begin
			nxt_state = hwrite ? CSF_ST_WR : CSF_ST_RD;
		end else if (state_ff == CSF_ST_RD && !ready_ff) begin
			nxt_state = CSF_ST_RD;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= CSF_ST_IDLE;
			idx_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
			ready_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			if (take) begin
				idx_ff <= addr_idx;
			end
			// reads wait one cycle so a write just before them is seen
			ready_ff <= !(take && word && !hwrite);
			if (state_ff == CSF_ST_RD && !ready_ff) begin
				hrdata_ff <= reg_rdata;
			end
		end
	end

	assign reg_wr = (state_ff == CSF_ST_WR);
	assign reg_idx = idx_ff;
	assign reg_wdata = hwdata[7:0];
	assign hreadyout = ready_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
endmodule : csf_ahb_slave
`default_nettype wire

// ---- logic/csf_status_reg.sv ----
// Behaviour
// - status byte reachable at file address 03h and 83h.
// - indirect bank bit one selects banks 2-3, zero selects banks 0-1.
// - direct bank field 01 selects bank 1, 00 selects bank 0.
// - banks are 128 bytes; software keeps upper bank bit zero.
// - watchdog flag set by power-up, watchdog clear and sleep.
// - watchdog flag cleared when the watchdog timer expires.
// - sleep flag set by power-up or watchdog clear.
// - sleep flag cleared by the sleep instruction.
// - zero flag follows whether the operation result is zero.
// - nibble carry from bit 3; inverted borrow on subtract.
// - carry from bit 7; inverted borrow on subtract.
// - flag-updating instruction writing status keeps flag logic on those bits.
// - software writes never change watchdog and sleep flags.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "csf_defines.svh"
`default_nettype none
module csf_status_reg #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite register bus
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// instruction stream file access
	input wire logic [6:0] core_file_addr,
	input wire logic core_wr_en,
	input wire logic [7:0] core_wr_data,
	input wire logic [7:0] core_indirect_ptr,
	// alu result
	input wire csf_pkg::csf_alu_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_logic_res,
	// core events
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timer_expired,
	// status and address outputs
	output logic [7:0] status_out,
	output logic [8:0] direct_addr,
	output logic [8:0] indirect_addr,
	output logic status_hit
);
	import csf_pkg::*;

	// haddr[9:2] carries the register index
	if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
		$error("csf_status_reg: ADDR_W must be 10 to 32");
	end

	function automatic logic is_status_idx(input logic [7:0] idx);
		is_status_idx = (idx == `CSF_STATUS_IDX_BANK0) || (idx == `CSF_STATUS_IDX_BANK1);
	endfunction : is_status_idx

	logic [7:0] status_ff, nxt_status;
	logic [8:0] direct_addr_ff;
	logic [8:0] indirect_addr_ff;
	logic status_hit_ff;

	logic bus_wr;
	logic [7:0] bus_idx;
	logic [7:0] bus_wdata;
	logic [31:0] bus_rdata;

	logic zero_val;
	logic nibble_carry_val;
	logic carry_val;
	logic zero_en;
	logic arith_en;

	csf_ahb_slave #(
		.ADDR_W(ADDR_W)
	) u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.reg_wr(bus_wr),
		.reg_idx(bus_idx),
		.reg_wdata(bus_wdata),
		.reg_rdata(bus_rdata)
	);

	csf_alu_flags u_flags (
		.alu_op(alu_op),
		.alu_a(alu_a),
		.alu_b(alu_b),
		.alu_logic_res(alu_logic_res),
		.zero_val(zero_val),
		.nibble_carry_val(nibble_carry_val),
		.carry_val(carry_val),
		.zero_en(zero_en),
		.arith_en(arith_en)
	);

	// current bank fields
	wire indirect_bank_select = status_ff[`CSF_BIT_INDIRECT_BANK];
	wire bank_select_high_reserved = status_ff[`CSF_BIT_BANK_HIGH];
	wire bank_select_low = status_ff[`CSF_BIT_BANK_LOW];

	// file address 03h in bank 0 or 83h in bank 1
	wire core_hit = (core_file_addr == `CSF_STATUS_FILE_ADDR) && !bank_select_high_reserved;
	wire core_wr = core_wr_en && core_hit;
	wire bus_hit = bus_wr && is_status_idx(bus_idx);

	// instruction write wins over a bus write in the same cycle
	wire any_wr = core_wr || bus_hit;
	wire [7:0] wr_data = core_wr ? core_wr_data : bus_wdata;
	wire flag_block = core_wr && zero_en;

	// bank select bits from writes only
	wire [7:0] wr_masked = (wr_data & `CSF_STATUS_WR_MASK) | (status_ff & ~`CSF_STATUS_WR_MASK);

	// watchdog expired flag: setting events win over expiry
	wire wdog_flag_set = watchdog_clear_instr || sleep_instr;
	wire nxt_wdog_flag = wdog_flag_set ? 1'b1
		: (watchdog_timer_expired ? 1'b0
		: status_ff[`CSF_BIT_WDOG_EXPIRED]);

	// sleep entered flag: sleep clears, watchdog clear sets
	wire nxt_sleep_flag = watchdog_clear_instr ? 1'b1
		: (sleep_instr ? 1'b0
		: status_ff[`CSF_BIT_SLEEP_ENTERED]);

	// flag logic overrides the data write on the three alu bits
	wire wr_flags = any_wr && !flag_block;
	wire nxt_zero = zero_en ? zero_val
		: (wr_flags ? wr_data[`CSF_BIT_ZERO] : status_ff[`CSF_BIT_ZERO]);
	wire nxt_nibble = arith_en ? nibble_carry_val
		: (wr_flags ? wr_data[`CSF_BIT_NIBBLE_CARRY] : status_ff[`CSF_BIT_NIBBLE_CARRY]);
	wire nxt_carry = arith_en ? carry_val
		: (wr_flags ? wr_data[`CSF_BIT_CARRY] : status_ff[`CSF_BIT_CARRY]);

	wire [7:0] upper_bits = any_wr ? wr_masked : status_ff;

	always_comb begin
		nxt_status = upper_bits;
		nxt_status[`CSF_BIT_WDOG_EXPIRED] = nxt_wdog_flag;
		nxt_status[`CSF_BIT_SLEEP_ENTERED] = nxt_sleep_flag;
		nxt_status[`CSF_BIT_ZERO] = nxt_zero;
		nxt_status[`CSF_BIT_NIBBLE_CARRY] = nxt_nibble;
		nxt_status[`CSF_BIT_CARRY] = nxt_carry;
	end

	// addresses use the bank fields as they stand after this cycle
	wire [1:0] nxt_bank = {nxt_status[`CSF_BIT_BANK_HIGH], nxt_status[`CSF_BIT_BANK_LOW]};
	wire [8:0] nxt_direct = {nxt_bank, core_file_addr};
	wire [8:0] nxt_indirect = {nxt_status[`CSF_BIT_INDIRECT_BANK], core_indirect_ptr};

	// bus read mux; unmapped indices read zero
	wire view_hit = (bus_idx == `CSF_ADDR_VIEW_IDX);
	assign bus_rdata = is_status_idx(bus_idx) ? {24'h00_0000, status_ff}
		: (view_hit ? {7'h00, indirect_addr_ff, 7'h00, direct_addr_ff} : 32'h0000_0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= `CSF_STATUS_RESET;
			direct_addr_ff <= 9'h000;
			indirect_addr_ff <= 9'h000;
			status_hit_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			direct_addr_ff <= nxt_direct;
			indirect_addr_ff <= nxt_indirect;
			status_hit_ff <= core_hit;
		end
	end

	assign status_out = status_ff;
	assign direct_addr = direct_addr_ff;
	assign indirect_addr = indirect_addr_ff;
	assign status_hit = status_hit_ff;

	wire unused_ok = &{1'b0, indirect_bank_select, bank_select_low};
endmodule : csf_status_reg
`default_nettype wire

// ---- verif/csf_status_monitor.sv ----
`default_nettype none
module csf_status_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	// core side
	input wire logic [6:0] core_file_addr,
	input wire csf_pkg::csf_alu_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_logic_res,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timer_expired,
	// outputs
	input wire logic [7:0] status_out,
	input wire logic [8:0] direct_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	import csf_pkg::*;
	logic [4:0] add_lo;
	logic [8:0] add_sum;
	assign add_lo = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
	assign add_sum = {1'b0, alu_a} + {1'b0, alu_b};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	watchdog_set_a: assert property ((watchdog_clear_instr || sleep_instr) |=> status_out[4])
		else $error("watchdog flag not set");
	watchdog_clear_a: assert property ((watchdog_timer_expired && !watchdog_clear_instr && !sleep_instr)
		|=> !status_out[4]) else $error("watchdog flag not cleared");
	sleep_set_a: assert property (watchdog_clear_instr |=> status_out[3])
		else $error("sleep flag not set");
	sleep_clear_a: assert property ((sleep_instr && !watchdog_clear_instr) |=> !status_out[3])
		else $error("sleep flag not cleared");
	event_hold_a: assert property (!(watchdog_clear_instr || sleep_instr || watchdog_timer_expired)
		|=> $stable(status_out[4:3])) else $error("event flags moved");
	zero_logic_a: assert property ((alu_op == CSF_ALU_LOGIC)
		|=> status_out[2] == ($past(alu_logic_res) == 8'h00)) else $error("zero flag wrong");
	add_flags_a: assert property ((alu_op == CSF_ALU_ADD) |=> status_out[2:0] ==
		{$past(add_sum[7:0]) == 8'h00, $past(add_lo[4]), $past(add_sum[8])}) else $error("add flags");
	sub_flags_a: assert property ((alu_op == CSF_ALU_SUB) |=> status_out[1:0] ==
		$past({alu_a[3:0] >= alu_b[3:0], alu_a >= alu_b})) else $error("sub flags");
	direct_map_a: assert property ($past(hresetn) |->
		direct_addr == {status_out[6:5], $past(core_file_addr)}) else $error("direct address");
	read_wait_a: assert property ((hsel && htrans[1] && hready && !hwrite)
		|=> !hreadyout ##1 hreadyout) else $error("read wait state");
	cover property (alu_op == CSF_ALU_ADD);
	cover property (sleep_instr);
	cover property (hsel && htrans[1] && hready && !hwrite);
endmodule : csf_status_monitor
bind csf_status_reg csf_status_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .core_file_addr, .alu_op, .alu_a, .alu_b, .alu_logic_res, .watchdog_clear_instr,
	.sleep_instr, .watchdog_timer_expired, .status_out, .direct_addr);
`default_nettype wire

// ---- verif/tb_top.sv ----
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import csf_pkg::*;
	logic hclk, hresetn, hwrite, hreadyout, hresp, we, wdc, slp, wexp, status_hit;
	logic [1:0] htrans;
	logic [11:0] haddr;
	logic [31:0] hwdata, hrdata, rd, rnd;
	logic [7:0] st_m, alu_a, alu_b, wd, ptr, status_out;
	logic [6:0] fa;
	logic [8:0] direct_addr, indirect_addr;
	csf_alu_op_t op;
	int failures = 0;
	int checks_done = 0;
	csf_status_reg uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .core_file_addr(fa),
		.core_wr_en(we), .core_wr_data(wd), .core_indirect_ptr(ptr), .alu_op(op), .alu_a,
		.alu_b, .alu_logic_res(alu_a), .watchdog_clear_instr(wdc), .sleep_instr(slp),
		.watchdog_timer_expired(wexp), .status_out, .direct_addr, .indirect_addr, .status_hit);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [7:0] model(logic [7:0] s, csf_alu_op_t o, logic [7:0] a,
		logic [7:0] b, logic w, logic [7:0] d, logic [2:0] ev);
		logic [8:0] r;
		r = (o == CSF_ALU_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		if (w) s[7:5] = d[7:5];
		if (w && o == CSF_ALU_NONE) s[2:0] = d[2:0];
		if (o != CSF_ALU_NONE) s[2] = ((o == CSF_ALU_LOGIC) ? a : r[7:0]) == 8'h00;
		if (o == CSF_ALU_ADD) s[1:0] = {({1'b0, a[3:0]} + b[3:0]) > 5'h0f, r[8]};
		if (o == CSF_ALU_SUB) s[1:0] = {a[3:0] >= b[3:0], a >= b};
		if (ev[2] || ev[1]) s[4] = 1'b1;
		else if (ev[0]) s[4] = 1'b0;
		if (ev[2]) s[3] = 1'b1;
		else if (ev[1]) s[3] = 1'b0;
		return s;
	endfunction : model
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			stop_test();
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		wait_rdy();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask : rdchk
	task automatic step(input csf_alu_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic w, input logic [7:0] d, input logic [2:0] ev);
		op <= o;
		alu_a <= a;
		alu_b <= b;
		we <= w;
		wd <= d;
		ptr <= b;
		fa <= w ? 7'h03 : a[6:0];
		{wdc, slp, wexp} <= ev;
		st_m = model(st_m, o, a, b, w, d, ev);
		@(posedge hclk);
		op <= CSF_ALU_NONE;
		we <= 1'b0;
		{wdc, slp, wexp} <= 3'b000;
		@(negedge hclk);
		chk(status_out, st_m);
		chk(direct_addr, {st_m[6:5], fa});
		chk(indirect_addr, {st_m[7], ptr});
		chk(status_hit, fa == 7'h03);
		@(posedge hclk);
	endtask : step
	initial begin
		hresetn = 1'b0;
		{hwrite, we, wdc, slp, wexp, htrans} = '0;
		{haddr, hwdata, alu_a, alu_b, wd, fa, ptr} = '0;
		op = CSF_ALU_NONE;
		st_m = 8'h18;
		rnd = 32'h0000_ad8c;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(status_out, 8'h18);
		rdchk(12'h00c, 32'h0000_0018);
		rdchk(12'h20c, 32'h0000_0018);
		rdchk(12'h100, 32'h0000_0000);
		step(CSF_ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h00, 3'b000);
		step(CSF_ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 3'b010);
		step(CSF_ALU_SUB, 8'h05, 8'h05, 1'b1, 8'h27, 3'b001);
		step(CSF_ALU_SUB, 8'h00, 8'h01, 1'b0, 8'h00, 3'b100);
		step(CSF_ALU_NONE, 8'h00, 8'h00, 1'b1, 8'h3f, 3'b011);
		step(CSF_ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 3'b110);
		for (int i = 0; i < 300; i++) begin
			rnd = lfsr(rnd);
			step(csf_alu_op_t'(rnd[1:0]), rnd[9:2], rnd[17:10], rnd[20:19] == 2'b00,
				rnd[25:18] & 8'h3f, rnd[31:30] == 2'b11 ? rnd[28:26] : 3'b000);
		end
		bus(1'b1, 12'h20c, 8'hff);
		st_m = (st_m & 8'h18) | 8'he7;
		rdchk(12'h00c, {24'h0, st_m});
		chk(indirect_addr, {1'b1, ptr});
		rdchk(12'h040, {7'h0, 1'b1, ptr, 7'h0, st_m[6:5], fa});
		bus(1'b1, 12'h100, 8'h00);
		bus(1'b1, 12'h00c, 8'h00);
		st_m = st_m & 8'h18;
		rdchk(12'h20c, {24'h0, st_m});
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
